// [inc/lcmc_pkg.sv]
// Package for the link compliance and margin control block.
// Assumes a single core clock domain and a plain strobed register port.
package lcmc_pkg;

  localparam int unsigned LCMC_ADDR_W = 12;
  localparam int unsigned LCMC_DATA_W = 16;

  localparam logic [11:0] LCMC_LINK_CONTROL_TWO_OFS = 12'h070;
  localparam logic [11:0] LCMC_MARGIN_STATUS_OFS = 12'h0f0;

  localparam int unsigned LCMC_MARGIN_LSB = 7;
  localparam int unsigned LCMC_MARGIN_MSB = 9;
  localparam int unsigned LCMC_MOD_COMP_BIT = 10;
  localparam int unsigned LCMC_SKIP_EN_BIT = 11;
  localparam int unsigned LCMC_COMP_DEEMPH_BIT = 12;

  localparam int unsigned LCMC_ST_MARGIN_LSB = 0;
  localparam int unsigned LCMC_ST_MARGIN_MSB = 2;
  localparam int unsigned LCMC_ST_USE_LANE_BIT = 3;
  localparam int unsigned LCMC_ST_MOD_PAT_BIT = 4;
  localparam int unsigned LCMC_ST_COMP_BIT = 5;
  localparam int unsigned LCMC_ST_DEEMPH_BIT = 6;
  localparam int unsigned LCMC_ST_PENDING_BIT = 7;

  localparam logic [2:0] LCMC_MARGIN_NORMAL = 3'h0;
  localparam logic [2:0] LCMC_MARGIN_MAX_LEGAL = 3'h5;
  localparam logic [2:0] LCMC_MARGIN_RESET = 3'h0;
  localparam logic LCMC_BIT_RESET = 1'h0;
  localparam logic [15:0] LCMC_RDATA_RESET = 16'h0000;

  localparam int unsigned LCMC_SKIP_INTERVAL_CYC = 1024;
  localparam int unsigned LCMC_LANES = 4;
  localparam int unsigned LCMC_LVL_W = 4;

  typedef struct packed {
    logic enter_poll_cfg;
    logic rcvr_lock;
    logic enter_poll_comp;
    logic exit_poll_comp;
    logic comp_via_force;
  } lcmc_ltssm_evt_t;

  typedef struct packed {
    logic [2:0] margin;
    logic use_lane_level;
    logic modified_pattern;
    logic comp_active;
    logic deemph_35;
  } lcmc_tx_ctl_t;

  typedef enum logic [1:0] {
    LCMC_CMP_IDLE,
    LCMC_CMP_NORMAL,
    LCMC_CMP_MODIFIED
  } lcmc_cmp_state_t;

endpackage

// [rtl/lcmc_skip_timer.sv]
// Periodic skip ordered set request timer for the compliance patterns.
// Assumes run_i comes from logic on the same clock.
`timescale 1ns/1ps
module lcmc_skip_timer import lcmc_pkg::*; #(
  parameter int unsigned INTERVAL = LCMC_SKIP_INTERVAL_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic skip_req_o
);

  localparam int unsigned CNT_W = $clog2(INTERVAL + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(INTERVAL - 1);

  logic [CNT_W-1:0] cnt;

  generate
    if (INTERVAL < 2) begin : g_bad
      $error("Skip interval must be at least two cycles.");
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt <= '0;
    end else if (cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      skip_req_o <= 1'b0;
    end else begin
      skip_req_o <= run_i && (cnt == LAST);
    end
  end

endmodule

// [rtl/lcmc_lane_level.sv]
// Per-lane transmitter drive level selection.
// Assumes lane level inputs come from lane registers on the same clock.
`timescale 1ns/1ps
module lcmc_lane_level import lcmc_pkg::*; #(
  parameter int unsigned LANES = LCMC_LANES,
  parameter int unsigned LVL_W = LCMC_LVL_W
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic use_lane_i,
  input wire logic low_swing_i,
  input wire logic [LANES-1:0][LVL_W-1:0] lane_tx_level_ctl0_i,
  input wire logic [LANES-1:0][LVL_W-1:0] lane_tx_level_ctl1_i,
  output logic [LANES-1:0][LVL_W-1:0] lane_level_o
);

  generate
    if (LANES < 1 || LVL_W < 1) begin : g_bad
      $error("Lane count and level width must be at least one.");
    end
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          lane_level_o[l] <= '0;
        end else if (!use_lane_i) begin
          lane_level_o[l] <= '0;
        end else if (low_swing_i) begin
          lane_level_o[l] <= lane_tx_level_ctl1_i[l];
        end else begin
          lane_level_o[l] <= lane_tx_level_ctl0_i[l];
        end
      end
    end
  endgenerate

endmodule

// [rtl/lcmc_top.sv]
// Upper field group of the second link control register and its effects on the transmitter.
// Assumes LTSSM events and lane registers share core_clk_i; rst_n_i is the fundamental reset.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Three-bit margin field; six and seven reserved.
// [RQ2] Margin field clears on polling configuration entry.
// [RQ3] Normal margin uses per-lane level registers.
// [RQ4] New margin applies after recovery receiver lock.
// [RQ5] Software retrains link after changing margin.
// [RQ6] Software touches these only during compliance testing.
// [RQ7] Modified pattern sent when bit set.
// [RQ8] Skip sets inserted periodically during compliance.
// [RQ9] De-emphasis bit applies in forced compliance.
// [RQ10] Software forces compliance via both ends, reset.
// [RQ11] Upper bits zero; fields sticky across warm resets.
module lcmc_top import lcmc_pkg::*; #(
  parameter int unsigned LANES = LCMC_LANES,
  parameter int unsigned LVL_W = LCMC_LVL_W,
  parameter int unsigned SKIP_INTERVAL = LCMC_SKIP_INTERVAL_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hot_reset_i,
  input wire logic [LCMC_ADDR_W-1:0] reg_addr_i,
  input wire logic [LCMC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [LCMC_DATA_W-1:0] reg_rdata_o,
  input wire lcmc_ltssm_evt_t ltssm_evt_i,
  input wire logic sel_deemph_35_i,
  input wire logic low_swing_i,
  input wire logic [LANES-1:0][LVL_W-1:0] lane_tx_level_ctl0_i,
  input wire logic [LANES-1:0][LVL_W-1:0] lane_tx_level_ctl1_i,
  output lcmc_tx_ctl_t tx_ctl_o,
  output logic [LANES-1:0][LVL_W-1:0] lane_level_o,
  output logic skip_req_o
);

  logic [2:0] transmit_margin_sel;
  logic modified_compliance_en;
  logic compliance_skip_en;
  logic compliance_deemph_sel;
  logic [2:0] margin_applied;
  logic margin_pending;
  lcmc_cmp_state_t cmp_state;
  lcmc_cmp_state_t next_cmp_state;
  logic deemph_35;
  logic wr_ctl2;
  logic margin_write_ok;
  logic [2:0] wr_margin;
  logic comp_run;
  logic [LCMC_DATA_W-1:0] ctl2_view;
  logic [LCMC_DATA_W-1:0] status_view;

  generate
    if (LANES < 1 || LVL_W < 1) begin : g_bad
      $error("Lane count and level width must be at least one.");
    end
  endgenerate

  // Register write decode.
  assign wr_ctl2 = reg_wr_i && (reg_addr_i == LCMC_LINK_CONTROL_TWO_OFS);
  assign wr_margin = reg_wdata_i[LCMC_MARGIN_MSB:LCMC_MARGIN_LSB];
  assign margin_write_ok = wr_margin <= LCMC_MARGIN_MAX_LEGAL; // RQ1

  // Margin field; hot reset leaves it alone, the fundamental reset and polling configuration entry clear it.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      transmit_margin_sel <= LCMC_MARGIN_RESET; // RQ11
    end else if (ltssm_evt_i.enter_poll_cfg) begin
      transmit_margin_sel <= LCMC_MARGIN_NORMAL; // RQ2
    end else if (wr_ctl2 && margin_write_ok) begin
      transmit_margin_sel <= wr_margin; // RQ1
    end
  end

  // Compliance control bits, sticky across hot reset.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      modified_compliance_en <= LCMC_BIT_RESET; // RQ11
      compliance_skip_en <= LCMC_BIT_RESET;
      compliance_deemph_sel <= LCMC_BIT_RESET;
    end else if (wr_ctl2) begin
      modified_compliance_en <= reg_wdata_i[LCMC_MOD_COMP_BIT];
      compliance_skip_en <= reg_wdata_i[LCMC_SKIP_EN_BIT];
      compliance_deemph_sel <= reg_wdata_i[LCMC_COMP_DEEMPH_BIT];
    end
  end

  // Applied margin follows the field only on receiver lock in recovery.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      margin_applied <= LCMC_MARGIN_RESET;
    end else if (ltssm_evt_i.rcvr_lock) begin
      margin_applied <= transmit_margin_sel; // RQ4
    end
  end

  // Pending flag shows a margin waiting for the next receiver lock.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      margin_pending <= 1'b0;
    end else if (ltssm_evt_i.rcvr_lock) begin
      margin_pending <= 1'b0; // RQ4
    end else begin
      margin_pending <= (transmit_margin_sel != margin_applied);
    end
  end

  // Compliance pattern state machine.
  always_comb begin
    next_cmp_state = cmp_state;
    case (cmp_state)
      LCMC_CMP_IDLE: begin
        if (ltssm_evt_i.enter_poll_comp) begin
          if (modified_compliance_en) begin
            next_cmp_state = LCMC_CMP_MODIFIED; // RQ7
          end else begin
            next_cmp_state = LCMC_CMP_NORMAL;
          end
        end
      end
      LCMC_CMP_NORMAL: begin
        if (ltssm_evt_i.exit_poll_comp) begin
          next_cmp_state = LCMC_CMP_IDLE;
        end
      end
      LCMC_CMP_MODIFIED: begin
        if (ltssm_evt_i.exit_poll_comp) begin
          next_cmp_state = LCMC_CMP_IDLE;
        end
      end
      default: begin
        next_cmp_state = LCMC_CMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || hot_reset_i) begin
      cmp_state <= LCMC_CMP_IDLE;
    end else begin
      cmp_state <= next_cmp_state;
    end
  end

  // De-emphasis choice is latched on compliance entry.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      deemph_35 <= 1'b0;
    end else if (cmp_state == LCMC_CMP_IDLE && ltssm_evt_i.enter_poll_comp) begin
      if (ltssm_evt_i.comp_via_force) begin
        deemph_35 <= compliance_deemph_sel; // RQ9
      end else begin
        deemph_35 <= sel_deemph_35_i;
      end
    end else if (cmp_state == LCMC_CMP_IDLE) begin
      deemph_35 <= sel_deemph_35_i;
    end
  end

  // Transmitter control outputs.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tx_ctl_o <= '0;
    end else begin
      tx_ctl_o.margin <= margin_applied; // RQ4
      tx_ctl_o.use_lane_level <= (margin_applied == LCMC_MARGIN_NORMAL); // RQ3
      tx_ctl_o.modified_pattern <= (cmp_state == LCMC_CMP_MODIFIED); // RQ7
      tx_ctl_o.comp_active <= (cmp_state != LCMC_CMP_IDLE);
      tx_ctl_o.deemph_35 <= deemph_35; // RQ9
    end
  end

  // Per-lane drive levels when the margin is in the normal range.
  lcmc_lane_level #(
    .LANES(LANES),
    .LVL_W(LVL_W)
  ) u_lane_level (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .use_lane_i(margin_applied == LCMC_MARGIN_NORMAL), // RQ3
    .low_swing_i(low_swing_i),
    .lane_tx_level_ctl0_i(lane_tx_level_ctl0_i),
    .lane_tx_level_ctl1_i(lane_tx_level_ctl1_i),
    .lane_level_o(lane_level_o)
  );

  // Skip ordered sets run only while a compliance pattern is sent.
  assign comp_run = compliance_skip_en && (cmp_state != LCMC_CMP_IDLE); // RQ8

  lcmc_skip_timer #(
    .INTERVAL(SKIP_INTERVAL)
  ) u_skip_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(comp_run),
    .skip_req_o(skip_req_o)
  );

  // Read views; bits outside the fields read as zero.
  always_comb begin
    ctl2_view = '0; // RQ11
    ctl2_view[LCMC_MARGIN_MSB:LCMC_MARGIN_LSB] = transmit_margin_sel;
    ctl2_view[LCMC_MOD_COMP_BIT] = modified_compliance_en;
    ctl2_view[LCMC_SKIP_EN_BIT] = compliance_skip_en;
    ctl2_view[LCMC_COMP_DEEMPH_BIT] = compliance_deemph_sel;
  end

  always_comb begin
    status_view = '0;
    status_view[LCMC_ST_MARGIN_MSB:LCMC_ST_MARGIN_LSB] = margin_applied;
    status_view[LCMC_ST_USE_LANE_BIT] = (margin_applied == LCMC_MARGIN_NORMAL);
    status_view[LCMC_ST_MOD_PAT_BIT] = (cmp_state == LCMC_CMP_MODIFIED);
    status_view[LCMC_ST_COMP_BIT] = (cmp_state != LCMC_CMP_IDLE);
    status_view[LCMC_ST_DEEMPH_BIT] = deemph_35;
    status_view[LCMC_ST_PENDING_BIT] = margin_pending;
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= LCMC_RDATA_RESET;
    end else if (reg_rd_i && reg_addr_i == LCMC_LINK_CONTROL_TWO_OFS) begin
      reg_rdata_o <= ctl2_view;
    end else if (reg_rd_i && reg_addr_i == LCMC_MARGIN_STATUS_OFS) begin
      reg_rdata_o <= status_view;
    end else begin
      reg_rdata_o <= LCMC_RDATA_RESET;
    end
  end

endmodule

// [verif/lcmc_top_properties.sv]
// Checker for the link compliance and margin control block.
// Assumes it is bound to lcmc_top and sees only its ports.
`timescale 1ns/1ps
module lcmc_top_properties import lcmc_pkg::*; #(
  parameter int unsigned LANES = LCMC_LANES,
  parameter int unsigned LVL_W = LCMC_LVL_W,
  parameter int unsigned SKIP_INTERVAL = LCMC_SKIP_INTERVAL_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hot_reset_i,
  input wire logic [LCMC_ADDR_W-1:0] reg_addr_i,
  input wire logic [LCMC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [LCMC_DATA_W-1:0] reg_rdata_o,
  input wire lcmc_ltssm_evt_t ltssm_evt_i,
  input wire logic sel_deemph_35_i,
  input wire logic [LANES-1:0][LVL_W-1:0] lane_level_o,
  input wire lcmc_tx_ctl_t tx_ctl_o,
  input wire logic skip_req_o
);
  logic mod_wr;
  logic deemph_wr;
  // Shadow of the written pattern and de-emphasis selects.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mod_wr <= 1'h0;
      deemph_wr <= 1'h0;
    end else if (reg_wr_i && reg_addr_i == LCMC_LINK_CONTROL_TWO_OFS) begin
      mod_wr <= reg_wdata_i[LCMC_MOD_COMP_BIT];
      deemph_wr <= reg_wdata_i[LCMC_COMP_DEEMPH_BIT];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_enter;
    ltssm_evt_i.enter_poll_comp && !tx_ctl_o.comp_active && !hot_reset_i ##1
      !ltssm_evt_i.exit_poll_comp && !hot_reset_i;
  endsequence
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside read slot");
  a_margin_legal: assert property (tx_ctl_o.margin <= LCMC_MARGIN_MAX_LEGAL)
    else $error("reserved margin applied");
  a_lane_margin: assert property (tx_ctl_o.margin != 3'h0 |->
    !tx_ctl_o.use_lane_level && lane_level_o == '0) else $error("lane level used");
  a_margin_hold: assert property ($changed(tx_ctl_o.margin) |->
    $past(ltssm_evt_i.rcvr_lock, 2)) else $error("margin changed without lock");
  a_field_clear: assert property (ltssm_evt_i.enter_poll_cfg ##1
    (reg_rd_i && reg_addr_i == LCMC_LINK_CONTROL_TWO_OFS) |=> reg_rdata_o[9:7] == 3'h0)
    else $error("margin field not cleared");
  a_mod_pattern: assert property (s_enter |=> tx_ctl_o.comp_active &&
    tx_ctl_o.modified_pattern == $past(mod_wr, 2)) else $error("wrong pattern");
  a_deemph_pick: assert property (s_enter |=> tx_ctl_o.deemph_35 ==
    ($past(ltssm_evt_i.comp_via_force, 2) ? $past(deemph_wr, 2) : $past(sel_deemph_35_i, 2)))
    else $error("wrong de-emphasis");
  a_skip_comp: assert property (skip_req_o |->
    tx_ctl_o.comp_active || $past(tx_ctl_o.comp_active)) else $error("skip outside compliance");
endmodule
bind lcmc_top lcmc_top_properties #(.LANES(LANES), .LVL_W(LVL_W),
  .SKIP_INTERVAL(SKIP_INTERVAL)) i_props (.core_clk_i, .rst_n_i, .hot_reset_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ltssm_evt_i,
  .sel_deemph_35_i, .lane_level_o, .tx_ctl_o, .skip_req_o);

// [verif/lcmc_link_partner.sv]
// Link partner model that turns bench requests into training event pulses.
// Assumes the core clock; slow_i adds one cycle of response delay.
`timescale 1ns/1ps
module lcmc_link_partner import lcmc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire lcmc_ltssm_evt_t req_i,
  output lcmc_ltssm_evt_t evt_o
);
  lcmc_ltssm_evt_t stage;
  // The force flag travels with the compliance entry pulse.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      stage <= '0;
      evt_o <= '0;
    end else begin
      stage <= req_i;
      evt_o <= slow_i ? stage : req_i;
    end
  end
endmodule

// [verif/lcmc_top_tb.sv]
// Self-checking bench for the link compliance and margin control block.
// Assumes the checker is bound to lcmc_top and the partner model drives events.
`timescale 1ns/1ps
module lcmc_top_tb import lcmc_pkg::*; ();
  localparam int SKIP = 4;
  logic clk, rst_n, hot_rst, wr, rd, sel_de, low_sw, slow, skip;
  logic [11:0] addr;
  logic [15:0] wdata, rdata;
  logic [3:0][3:0] ctl0, ctl1, lvl;
  lcmc_ltssm_evt_t req, evt;
  lcmc_tx_ctl_t tx;
  int n_errors, comparisons;
  always #2 clk = ~clk;
  lcmc_link_partner i_partner (.core_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
    .req_i(req), .evt_o(evt));
  lcmc_top #(.SKIP_INTERVAL(SKIP)) i_dut (.core_clk_i(clk), .rst_n_i(rst_n),
    .hot_reset_i(hot_rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .ltssm_evt_i(evt), .sel_deemph_35_i(sel_de),
    .low_swing_i(low_sw), .lane_tx_level_ctl0_i(ctl0), .lane_tx_level_ctl1_i(ctl1),
    .tx_ctl_o(tx), .lane_level_o(lvl), .skip_req_o(skip));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("rdata", exp, rdata);
  endtask
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    req <= e;
    @(posedge clk);
    req <= '0;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic t_margin;
    logic [2:0] app;
    app = 3'h0;
    for (int m = 0; m < 8; m++) begin
      wr_reg(12'h070, 16'(m) << 7);
      rd_reg(12'h070, 16'(m <= 5 ? m : app) << 7);
      check("held", {13'h0, app}, {13'h0, tx.margin});
      pulse(5'h08);
      if (m <= 5) app = 3'(m);
      check("applied", {12'h0, app, app == 3'h0}, {12'h0, tx[6:3]});
      check("lane", app == 3'h0 ? ctl0 : 16'h0, lvl);
    end
    @(posedge clk);
    req <= 5'h10;
    @(posedge clk);
    req <= '0;
    rd_reg(12'h070, 16'h0000);
    low_sw <= 1'b1;
    pulse(5'h08);
    check("lane", ctl1, lvl);
  endtask
  task automatic t_comp;
    int last;
    int gap;
    last = -1;
    gap = 0;
    wr_reg(12'h070, 16'h1c00);
    pulse(5'h05);
    check("forced", 16'h0007, {13'h0, tx[2:0]});
    rd_reg(12'h0f0, 16'h0078);
    for (int i = 0; i < 40 && gap == 0; i++) begin
      @(posedge clk);
      #1;
      if (skip === 1'b1 && last >= 0) gap = i - last;
      if (skip === 1'b1) last = i;
    end
    check("skip gap", 16'(SKIP), 16'(gap));
    pulse(5'h02);
    check("exit", 16'h0, {14'h0, tx[2:1]});
    wr_reg(12'h070, 16'h1000);
    slow <= 1'b1;
    pulse(5'h04);
    check("plain", 16'h0002, {13'h0, tx[2:0]});
    pulse(5'h02);
    wr_reg(12'h070, 16'h0000);
  endtask
  task automatic t_sticky;
    wr_reg(12'h070, 16'h0c80);
    sel_de <= 1'b1;
    pulse(5'h04);
    check("entry", 16'h0007, {13'h0, tx[2:0]});
    @(posedge clk);
    hot_rst <= 1'b1;
    @(posedge clk);
    hot_rst <= 1'b0;
    rd_reg(12'h070, 16'h0c80);
    check("hot exit", 16'h0000, {14'h0, tx[2:1]});
    rd_reg(12'h0f0, 16'h00c8);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(12'h070, 16'h0000);
  endtask
  task automatic summarize;
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {hot_rst, wr, rd, sel_de, low_sw, slow} = 6'h00;
    addr = 12'h0;
    wdata = 16'h0;
    req = '0;
    ctl0 = 16'h4321;
    ctl1 = 16'h8765;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(12'h070, 16'h0000);
    rd_reg(12'h074, 16'h0000);
    wr_reg(12'h070, 16'hffff);
    rd_reg(12'h070, 16'h1c00);
    t_margin;
    t_comp;
    t_sticky;
    summarize;
  end
endmodule
